// ---- logic/efc_pkg.sv ----
// constants shared by the earth-fault configuration switch block
package efc_pkg;
    // ---------------------------------------------------------------
    // register byte offsets
    // ---------------------------------------------------------------
    localparam logic [5:0] EFC_OFF_ROUTE     = 6'h00;
    localparam logic [5:0] EFC_OFF_TRANS     = 6'h04;
    localparam logic [5:0] EFC_OFF_ROUTE_ALT = 6'h08;
    localparam logic [5:0] EFC_OFF_TRANS_ALT = 6'h0C;
    localparam logic [5:0] EFC_OFF_BLK1      = 6'h10;
    localparam logic [5:0] EFC_OFF_BLK2      = 6'h14;
    localparam logic [5:0] EFC_OFF_BLK3      = 6'h18;
    localparam logic [5:0] EFC_OFF_CTRL      = 6'h1C;
    localparam logic [5:0] EFC_OFF_STATUS    = 6'h20;
    // ---------------------------------------------------------------
    // reset values
    // ---------------------------------------------------------------
    localparam logic [7:0] EFC_ROUTE_RST = 8'h14;
    localparam logic [7:0] EFC_TRANS_RST = 8'h10;
    localparam logic [7:0] EFC_BLK_RST   = 8'h00;
    localparam logic [7:0] EFC_CTRL_RST  = 8'h00;
    // ---------------------------------------------------------------
    // stage routing field positions (bits 1:0 are the characteristic)
    // ---------------------------------------------------------------
    localparam int EFC_RT_LOW_START  = 2;
    localparam int EFC_RT_LOW_TRIP   = 3;
    localparam int EFC_RT_HIGH_START = 4;
    localparam int EFC_RT_HIGH_TRIP  = 5;
    localparam int EFC_RT_INT_START  = 6;
    localparam int EFC_RT_INT_TRIP   = 7;
    // ---------------------------------------------------------------
    // transient blocking field positions
    // ---------------------------------------------------------------
    localparam int EFC_TB_ANGLE_EN   = 0;
    localparam int EFC_TB_RATED_110  = 1;
    localparam int EFC_TB_START_INH  = 2;
    localparam int EFC_TB_LOW_OFF    = 3;
    localparam int EFC_TB_SPEEDUP    = 4;
    localparam int EFC_TB_INT_OFF    = 5;
    localparam int EFC_TB_STAGE_MAN  = 6;
    // ---------------------------------------------------------------
    // blocking switchgroup field positions
    // ---------------------------------------------------------------
    localparam int EFC_BG_LOW        = 0;
    localparam int EFC_BG_HIGH       = 1;
    localparam int EFC_BG_INT        = 2;
    localparam int EFC_BG_ANGLE      = 3;
    localparam int EFC_BG_BANK       = 4;
    localparam int EFC_BG_RST_LO     = 5;
    localparam int EFC_BG_RST_HI     = 7;
    // control register fields
    localparam int EFC_CT_MAN_W      = 3;
    localparam int EFC_CT_RESET      = 4;
    // ---------------------------------------------------------------
    // timing
    // ---------------------------------------------------------------
    localparam int unsigned EFC_CLK_MHZ       = 125;
    localparam int unsigned EFC_HOLD_HIGH_MS  = 400;
    localparam int unsigned EFC_HOLD_BOTH_MS  = 1000;
    localparam int unsigned EFC_HOLD_04_CYC   =
        EFC_HOLD_HIGH_MS * EFC_CLK_MHZ * 1000;
    localparam int unsigned EFC_HOLD_1S_CYC   =
        EFC_HOLD_BOTH_MS * EFC_CLK_MHZ * 1000;
    localparam int EFC_TMR_W = 27;
    // axi responses
    localparam logic [1:0] EFC_RESP_OKAY   = 2'h0;
    localparam logic [1:0] EFC_RESP_SLVERR = 2'h2;
endpackage

// ---- logic/efc_config_switches.sv ----
// earth-fault configuration switches with axi4-lite register access
//
// The register offsets and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module efc_config_switches
    import efc_pkg::*;
#(
    parameter int unsigned HOLD_04_CYC = EFC_HOLD_04_CYC,
    parameter int unsigned HOLD_1S_CYC = EFC_HOLD_1S_CYC
)(
    input  wire logic        CLOCK,
    input  wire logic        RST_N,
    input  wire logic [5:0]  S_AXI_AWADDR,
    input  wire logic        S_AXI_AWVALID,
    output logic             S_AXI_AWREADY,
    input  wire logic [31:0] S_AXI_WDATA,
    input  wire logic [3:0]  S_AXI_WSTRB,
    input  wire logic        S_AXI_WVALID,
    output logic             S_AXI_WREADY,
    output logic [1:0]       S_AXI_BRESP,
    output logic             S_AXI_BVALID,
    input  wire logic        S_AXI_BREADY,
    input  wire logic [5:0]  S_AXI_ARADDR,
    input  wire logic        S_AXI_ARVALID,
    output logic             S_AXI_ARREADY,
    output logic [31:0]      S_AXI_RDATA,
    output logic [1:0]       S_AXI_RRESP,
    output logic             S_AXI_RVALID,
    input  wire logic        S_AXI_RREADY,
    input  wire logic        BLOCK_INPUT_ONE,
    input  wire logic        BLOCK_INPUT_TWO,
    input  wire logic        REMOTE_RESET_INPUT,
    input  wire logic        BASIC_ANGLE_CONTROL_INPUT,
    input  wire logic        LOW_START,
    input  wire logic        LOW_TRIP,
    input  wire logic        HIGH_START,
    input  wire logic        HIGH_TRIP,
    input  wire logic        INT_START,
    input  wire logic        INT_TRIP,
    input  wire logic        TRANSIENT_EVAL,
    output logic             RECLOSE_INITIATION_OUTPUT,
    output logic [1:0]       CHAR_MODE,
    output logic             RATED_110V,
    output logic             TRANSIENT_INHIBIT,
    output logic             INT_ENABLE,
    output logic             LOW_BLOCK,
    output logic             HIGH_BLOCK,
    output logic [2:0]       STAGE_OUT,
    output logic [2:0]       INDICATOR
);
    // ---------------------------------------------------------------
    // registers and state
    // ---------------------------------------------------------------
    logic [7:0]           route_reg, route_alt_reg;
    logic [7:0]           trans_reg, trans_alt_reg;
    logic [7:0]           blk_reg [3];
    logic [7:0]           ctrl_reg;
    logic [3:0]           pin_meta_reg, pin_sync_reg;
    logic                 aw_hold_reg, w_hold_reg;
    logic [5:0]           aw_addr_reg;
    logic [31:0]          w_data_reg;
    logic                 w_strb0_reg;
    logic                 sw_reset_reg;
    logic                 eval_d_reg;
    logic [EFC_TMR_W-1:0] t04_reg, t1_reg;
    logic [2:0]           hold_reg, ind_reg;
    logic [2:0]           sig;
    logic [2:0]           trip_vec;
    logic [5:0]           stage_vec;
    logic [7:0]           route_eff;
    logic [2:0]           bg_low, bg_high, bg_int, bg_ang, bg_bank, bg_rst;
    logic                 ba_act, alt_bank, rst_req, eval_rise, do_write;
    logic                 t04_act, t1_act, cur_start;

    // ---------------------------------------------------------------
    // pin synchronisers
    // ---------------------------------------------------------------
    // two flops on every external control pin
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            pin_meta_reg <= 4'h0;
            pin_sync_reg <= 4'h0;
        end else begin
            pin_meta_reg <= {BASIC_ANGLE_CONTROL_INPUT, REMOTE_RESET_INPUT,
                             BLOCK_INPUT_TWO, BLOCK_INPUT_ONE};
            pin_sync_reg <= pin_meta_reg;
        end
    end
    assign sig = pin_sync_reg[2:0];

    // ---------------------------------------------------------------
    // blocking switchgroup matrix
    // ---------------------------------------------------------------
    // each group ties one control signal to its targets
    for (genvar g = 0; g < 3; g++) begin : g_blk
        assign bg_low[g]  = sig[g] & blk_reg[g][EFC_BG_LOW];
        assign bg_high[g] = sig[g] & blk_reg[g][EFC_BG_HIGH];
        assign bg_int[g]  = sig[g] & blk_reg[g][EFC_BG_INT];
        assign bg_ang[g]  = sig[g] & blk_reg[g][EFC_BG_ANGLE];
        assign bg_bank[g] = sig[g] & blk_reg[g][EFC_BG_BANK];
        assign bg_rst[g]  = sig[g] &
                            (|blk_reg[g][EFC_BG_RST_HI:EFC_BG_RST_LO]);
    end

    // bank choice only swaps routing; blocking group stays main
    assign alt_bank  = |bg_bank;
    assign route_eff = alt_bank ? route_alt_reg : route_reg;
    assign ba_act    = trans_reg[EFC_TB_ANGLE_EN] &
                       (pin_sync_reg[3] | (|bg_ang));
    assign rst_req   = sw_reset_reg | (|bg_rst);
    assign stage_vec = {INT_TRIP, INT_START, HIGH_TRIP, HIGH_START,
                        LOW_TRIP, LOW_START};
    assign trip_vec  = {INT_TRIP, HIGH_TRIP, LOW_TRIP};
    assign eval_rise = TRANSIENT_EVAL & ~eval_d_reg;
    assign t04_act   = t04_reg != '0;
    assign t1_act    = t1_reg != '0;
    assign cur_start = LOW_START | HIGH_START;

    // ---------------------------------------------------------------
    // axi4-lite slave
    // ---------------------------------------------------------------
    assign S_AXI_AWREADY = ~aw_hold_reg & ~S_AXI_BVALID;
    assign S_AXI_WREADY  = ~w_hold_reg & ~S_AXI_BVALID;
    assign S_AXI_ARREADY = ~S_AXI_RVALID;
    assign do_write      = aw_hold_reg & w_hold_reg & ~S_AXI_BVALID;

    // address and data are caught in either order
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            aw_hold_reg <= 1'b0;
            w_hold_reg  <= 1'b0;
            aw_addr_reg <= 6'h00;
            w_data_reg  <= 32'h0000_0000;
            w_strb0_reg <= 1'b0;
        end else begin
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_hold_reg <= 1'b1;
                aw_addr_reg <= S_AXI_AWADDR;
            end else if (do_write) begin
                aw_hold_reg <= 1'b0;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_hold_reg  <= 1'b1;
                w_data_reg  <= S_AXI_WDATA;
                w_strb0_reg <= S_AXI_WSTRB[0];
            end else if (do_write) begin
                w_hold_reg <= 1'b0;
            end
        end
    end

    // write response
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP  <= EFC_RESP_OKAY;
        end else if (do_write) begin
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP  <= (aw_addr_reg <= EFC_OFF_CTRL &&
                             aw_addr_reg[1:0] == 2'h0) ?
                            EFC_RESP_OKAY : EFC_RESP_SLVERR;
        end else if (S_AXI_BREADY) begin
            S_AXI_BVALID <= 1'b0;
        end
    end

    // configuration registers; readback returns the stored register values
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            route_reg     <= EFC_ROUTE_RST;
            route_alt_reg <= EFC_ROUTE_RST;
            trans_reg     <= EFC_TRANS_RST;
            trans_alt_reg <= EFC_TRANS_RST;
            blk_reg[0]    <= EFC_BLK_RST;
            blk_reg[1]    <= EFC_BLK_RST;
            blk_reg[2]    <= EFC_BLK_RST;
            ctrl_reg      <= EFC_CTRL_RST;
        end else if (do_write && w_strb0_reg) begin
            unique case (aw_addr_reg)
                EFC_OFF_ROUTE:     route_reg     <= w_data_reg[7:0];
                EFC_OFF_TRANS:     trans_reg     <= w_data_reg[7:0];
                EFC_OFF_ROUTE_ALT: route_alt_reg <= w_data_reg[7:0];
                EFC_OFF_TRANS_ALT: trans_alt_reg <= w_data_reg[7:0];
                EFC_OFF_BLK1:      blk_reg[0]    <= w_data_reg[7:0];
                EFC_OFF_BLK2:      blk_reg[1]    <= w_data_reg[7:0];
                EFC_OFF_BLK3:      blk_reg[2]    <= w_data_reg[7:0];
                EFC_OFF_CTRL:      ctrl_reg      <= {5'h00,
                                       w_data_reg[EFC_CT_MAN_W-1:0]};
                default:           ctrl_reg      <= ctrl_reg;
            endcase
        end
    end

    // write-one reset strobe, one cycle
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            sw_reset_reg <= 1'b0;
        end else begin
            sw_reset_reg <= do_write && w_strb0_reg &&
                            aw_addr_reg == EFC_OFF_CTRL &&
                            w_data_reg[EFC_CT_RESET];
        end
    end

    // read channel
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA  <= 32'h0000_0000;
            S_AXI_RRESP  <= EFC_RESP_OKAY;
        end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            S_AXI_RVALID <= 1'b1;
            S_AXI_RRESP  <= EFC_RESP_OKAY;
            unique case (S_AXI_ARADDR)
                EFC_OFF_ROUTE:     S_AXI_RDATA <= {24'h0, route_reg};
                EFC_OFF_TRANS:     S_AXI_RDATA <= {24'h0, trans_reg};
                EFC_OFF_ROUTE_ALT: S_AXI_RDATA <= {24'h0, route_alt_reg};
                EFC_OFF_TRANS_ALT: S_AXI_RDATA <= {24'h0, trans_alt_reg};
                EFC_OFF_BLK1:      S_AXI_RDATA <= {24'h0, blk_reg[0]};
                EFC_OFF_BLK2:      S_AXI_RDATA <= {24'h0, blk_reg[1]};
                EFC_OFF_BLK3:      S_AXI_RDATA <= {24'h0, blk_reg[2]};
                EFC_OFF_CTRL:      S_AXI_RDATA <= {24'h0, ctrl_reg};
                EFC_OFF_STATUS:    S_AXI_RDATA <= {24'h0, ind_reg,
                                       alt_bank, ba_act, t1_act, t04_act,
                                       RECLOSE_INITIATION_OUTPUT};
                default: begin
                    S_AXI_RDATA <= 32'h0000_0000;
                    S_AXI_RRESP <= EFC_RESP_SLVERR;
                end
            endcase
        end else if (S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // evaluation hold timers
    // ---------------------------------------------------------------
    // loaded only at evaluation start; later edits never touch them
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            eval_d_reg <= 1'b0;
            t04_reg    <= '0;
            t1_reg     <= '0;
        end else begin
            eval_d_reg <= TRANSIENT_EVAL;
            if (eval_rise && trans_reg[EFC_TB_LOW_OFF])
                t04_reg <= EFC_TMR_W'(HOLD_04_CYC);
            else if (t04_act)
                t04_reg <= t04_reg - 1'b1;
            if (eval_rise && trans_reg[EFC_TB_SPEEDUP])
                t1_reg <= EFC_TMR_W'(HOLD_1S_CYC);
            else if (t1_act)
                t1_reg <= t1_reg - 1'b1;
        end
    end

    // ---------------------------------------------------------------
    // stage control outputs
    // ---------------------------------------------------------------
    // registered so a change acts on the next clock cycle
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            RECLOSE_INITIATION_OUTPUT <= 1'b0;
            CHAR_MODE                 <= 2'h0;
            RATED_110V                <= 1'b0;
            TRANSIENT_INHIBIT         <= 1'b0;
            INT_ENABLE                <= 1'b0;
            LOW_BLOCK                 <= 1'b0;
            HIGH_BLOCK                <= 1'b0;
        end else begin
            RECLOSE_INITIATION_OUTPUT <=
                |(route_eff[EFC_RT_INT_TRIP:EFC_RT_LOW_START] & stage_vec);
            // control swaps 0/-90 and cos/sin
            CHAR_MODE <= {route_eff[1], route_eff[0] ^ ba_act};
            RATED_110V <= trans_reg[EFC_TB_RATED_110];
            TRANSIENT_INHIBIT <=
                trans_reg[EFC_TB_START_INH] & cur_start;
            INT_ENABLE <= ~trans_reg[EFC_TB_INT_OFF] & ~(|bg_int) &
                          ~(trans_reg[EFC_TB_START_INH] & cur_start);
            LOW_BLOCK  <= trans_reg[EFC_TB_LOW_OFF] | t1_act | (|bg_low);
            HIGH_BLOCK <= t04_act | t1_act | (|bg_high);
        end
    end

    // ---------------------------------------------------------------
    // manual reset policy
    // ---------------------------------------------------------------
    // a trip in the reset cycle wins over the clear
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            hold_reg  <= 3'h0;
            ind_reg   <= 3'h0;
            STAGE_OUT <= 3'h0;
            INDICATOR <= 3'h0;
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (ctrl_reg[i] && trip_vec[i])
                    ind_reg[i] <= 1'b1;
                else if (!ctrl_reg[i] || rst_req)
                    ind_reg[i] <= trip_vec[i];
                if (ctrl_reg[i] && trans_reg[EFC_TB_STAGE_MAN] && trip_vec[i])
                    hold_reg[i] <= 1'b1;
                else if (rst_req || !ctrl_reg[i])
                    hold_reg[i] <= 1'b0;
            end
            STAGE_OUT <= trip_vec | hold_reg;
            INDICATOR <= ind_reg;
        end
    end

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RST_N);

    sequence s_eval_low_off;
        eval_rise && trans_reg[EFC_TB_LOW_OFF];
    endsequence
    sequence s_eval_speedup;
        eval_rise && trans_reg[EFC_TB_SPEEDUP];
    endsequence

    property p_route_reset;
        $rose(RST_N) |-> route_reg == 8'h14 && trans_reg == 8'h10;
    endproperty
    a_route_reset: assert property (p_route_reset)
        else $error("config groups not at default after reset");
    property p_low_start_ar;
        route_eff[EFC_RT_LOW_START] && LOW_START
            |=> RECLOSE_INITIATION_OUTPUT;
    endproperty
    a_low_start_ar: assert property (p_low_start_ar)
        else $error("low-set start not routed to reclose");
    property p_low_trip_ar;
        route_eff[EFC_RT_LOW_TRIP] && LOW_TRIP |=> RECLOSE_INITIATION_OUTPUT;
    endproperty
    a_low_trip_ar: assert property (p_low_trip_ar)
        else $error("low-set trip not routed to reclose");
    property p_ar_quiet;
        (route_eff[EFC_RT_INT_TRIP:EFC_RT_LOW_START] & stage_vec) == 6'h00
            |=> !RECLOSE_INITIATION_OUTPUT;
    endproperty
    a_ar_quiet: assert property (p_ar_quiet)
        else $error("reclose raised by unrouted signal");
    property p_angle_ignored;
        !trans_reg[EFC_TB_ANGLE_EN] |=> CHAR_MODE == $past(route_eff[1:0]);
    endproperty
    a_angle_ignored: assert property (p_angle_ignored)
        else $error("angle control acted while disabled");
    property p_rated;
        ##1 RATED_110V == $past(trans_reg[EFC_TB_RATED_110]);
    endproperty
    a_rated: assert property (p_rated)
        else $error("rated voltage select wrong");
    property p_inhibit;
        trans_reg[EFC_TB_START_INH] && cur_start
            |=> TRANSIENT_INHIBIT && !INT_ENABLE;
    endproperty
    a_inhibit: assert property (p_inhibit)
        else $error("current start did not inhibit");
    property p_hold04;
        s_eval_low_off |=> ##1 (HIGH_BLOCK && LOW_BLOCK) [*3];
    endproperty
    a_hold04: assert property (p_hold04)
        else $error("high-set not held after evaluation");
    property p_hold1s;
        s_eval_speedup |=> ##1 (HIGH_BLOCK && LOW_BLOCK) [*3];
    endproperty
    a_hold1s: assert property (p_hold1s)
        else $error("speed-up block missing");
    property p_int_off;
        trans_reg[EFC_TB_INT_OFF] |=> !INT_ENABLE;
    endproperty
    a_int_off: assert property (p_int_off)
        else $error("intermittent enabled while disabled");
    property p_stage_latch;
        hold_reg[0] && !rst_req && ctrl_reg[0] |=> hold_reg[0];
    endproperty
    a_stage_latch: assert property (p_stage_latch)
        else $error("stage latch lost without reset");
endmodule
`default_nettype wire

// ---- sim/efc_partner.sv ----
// far-side model: stage signals and external control pins
`timescale 1ns/1ps
`default_nettype none
module efc_partner (
    input  wire logic        clock,
    input  wire logic [10:0] stim,
    output logic      [10:0] pins = 11'h000
);
    // pins follow the command one clock later, like registered relays
    always @(posedge clock) begin
        pins <= stim;
    end
endmodule
`default_nettype wire

// ---- sim/test_efc_config_switches.sv ----
// self-checking bench for the earth-fault configuration switches
`timescale 1ns/1ps
`default_nettype none
module test_efc_config_switches;
    import efc_pkg::*;
    logic        clock = 0, rst_n = 0, awvalid = 0, wvalid = 0;
    logic        bready = 0, arvalid = 0, rready = 0;
    logic [5:0]  awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, got;
    logic [10:0] stim = 0, p;
    logic [1:0]  bresp, rresp, char_mode, resp;
    logic        awready, wready, bvalid, arready, rvalid, reclose;
    logic        rated, inhibit, int_en, low_blk, high_blk;
    logic [2:0]  stage, ind;
    int          error_cnt = 0, num_checks = 0, cyc = 0;
    // ---------------------------------------------------------------
    // clock, partner and block
    // ---------------------------------------------------------------
    always #4 clock = ~clock;
    efc_partner FAR (.clock(clock), .stim(stim), .pins(p));
    efc_config_switches #(.HOLD_04_CYC(20), .HOLD_1S_CYC(40)) DUT (
        .CLOCK(clock), .RST_N(rst_n), .S_AXI_AWADDR(awaddr),
        .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid),
        .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
        .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
        .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
        .S_AXI_RREADY(rready), .BLOCK_INPUT_ONE(p[7]),
        .BLOCK_INPUT_TWO(p[8]), .REMOTE_RESET_INPUT(p[9]),
        .BASIC_ANGLE_CONTROL_INPUT(p[10]), .LOW_START(p[0]),
        .LOW_TRIP(p[1]), .HIGH_START(p[2]), .HIGH_TRIP(p[3]),
        .INT_START(p[4]), .INT_TRIP(p[5]), .TRANSIENT_EVAL(p[6]),
        .RECLOSE_INITIATION_OUTPUT(reclose), .CHAR_MODE(char_mode),
        .RATED_110V(rated), .TRANSIENT_INHIBIT(inhibit),
        .INT_ENABLE(int_en), .LOW_BLOCK(low_blk), .HIGH_BLOCK(high_blk),
        .STAGE_OUT(stage), .INDICATOR(ind));
    // ---------------------------------------------------------------
    // report, compare and bus tasks
    // ---------------------------------------------------------------
    task automatic summarize;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %0t got %h expected %h", $time, g, e);
        end
    endtask
    // handshakes seen at the falling edge complete at the next rise
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        logic ta, tw, tb;
        @(posedge clock); // let an edge pass between transfers
        awaddr <= a;
        wdata <= d;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        do begin
            @(negedge clock);
            ta = awvalid & awready;
            tw = wvalid & wready;
            tb = bready & bvalid;
            resp = bresp;
            @(posedge clock);
            if (ta) awvalid <= 0;
            if (tw) wvalid <= 0;
            if (tb) bready <= 0;
        end while (!tb);
    endtask
    task automatic rd(input logic [5:0] a);
        logic ta, t;
        @(posedge clock); // let an edge pass between transfers
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        do begin
            @(negedge clock);
            ta = arvalid & arready;
            t = rready & rvalid;
            got = rdata;
            resp = rresp;
            @(posedge clock);
            if (ta) arvalid <= 0;
            if (t) rready <= 0;
        end while (!t);
    endtask
    // hang guard
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            error_cnt++;
            summarize();
        end
    end
    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        repeat (12) @(posedge clock);
        rst_n <= 1;
        @(posedge clock);
        rd(6'h00);
        chk(got, 32'h14);
        rd(6'h04);
        chk(got, 32'h10);
        rd(6'h24);
        chk({got[29:0], resp}, 32'h2);
        wr(6'h20, 32'h0);
        chk(resp, 32'h2);
        stim <= 11'h400;
        for (int c = 0; c < 4; c++) begin
            wr(6'h00, 32'(c));
            repeat (4) @(posedge clock);
            chk(char_mode, 32'(c));
        end
        wr(6'h04, 32'h01);
        repeat (4) @(posedge clock);
        chk(char_mode, 32'h2);
        for (int b = 2; b < 8; b++) begin
            wr(6'h00, 32'(1 << b));
            stim <= 11'(1 << (b - 2));
            repeat (4) @(posedge clock);
            chk(reclose, 1);
            stim <= 11'h3F ^ 11'(1 << (b - 2));
            repeat (4) @(posedge clock);
            chk(reclose, 0);
        end
        wr(6'h04, 32'h06);
        stim <= 11'h001;
        repeat (4) @(posedge clock);
        chk({rated, inhibit, int_en}, 6);
        wr(6'h04, 32'h20);
        repeat (4) @(posedge clock);
        chk({rated, inhibit, int_en}, 0);
        stim <= 0;
        wr(6'h04, 32'h08);
        stim <= 11'h040;
        repeat (6) @(posedge clock);
        chk({low_blk, high_blk}, 3);
        repeat (30) @(posedge clock);
        chk({low_blk, high_blk}, 2);
        chk(int_en, 1);
        stim <= 0;
        wr(6'h04, 32'h10);
        stim <= 11'h040;
        repeat (30) @(posedge clock);
        chk({low_blk, high_blk}, 3);
        repeat (20) @(posedge clock);
        chk({low_blk, high_blk}, 0);
        wr(6'h1C, 32'h01);
        wr(6'h04, 32'h40);
        stim <= 11'h002;
        repeat (4) @(posedge clock);
        stim <= 0;
        repeat (4) @(posedge clock);
        chk({stage, ind}, 32'h09);
        wr(6'h1C, 32'h11);
        repeat (4) @(posedge clock);
        chk({stage, ind}, 32'h00);
        wr(6'h04, 32'h00);
        stim <= 11'h002;
        repeat (4) @(posedge clock);
        stim <= 0;
        repeat (4) @(posedge clock);
        chk({stage, ind}, 32'h01);
        summarize();
    end
endmodule
`default_nettype wire
